// [logic/smcr_bank.sv]
// Servo motion command register bank behind a parsed Modbus request port
// Contract
// - Writing 1 starts, 0 ends simultaneous start
// - Settings accepted only by function 10h
// - Force stop: 1 is on, 0 off
// - Force stop ignores the broadcast enable setting
// - Override applies only while selection input on
// - Forward torque limit 16-bit, read and write
// - Reverse torque limit 16-bit, read and write
// - Readable registers answer function 03h
// - Current position equals the position monitor value
// - Current speed reported in r/min or mm/s
// - Current torque read-only, 0.1 percent steps
// - Target cam used only when item 49 zero
// - Active cam reported while cam control active
// - Cam cycle length kept in volatile flops only
// - Cam stroke length kept in volatile flops only
`timescale 1ns/1ps
module smcr_bank (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // Parsed Modbus request
  input  wire logic        req_valid_in,
  input  wire logic        req_broadcast_in,
  input  wire logic [7:0]  req_func_in,
  input  wire logic [15:0] req_addr_in,
  input  wire logic [15:0] req_qty_in,
  input  wire logic [31:0] req_wdata_in,
  // Broadcast enable setting held elsewhere
  input  wire logic        broadcast_enable_in,
  // Motion state
  input  wire logic [31:0] actual_position_in,
  input  wire logic [31:0] actual_speed_in,
  input  wire logic [15:0] actual_torque_in,
  input  wire logic [7:0]  active_cam_in,
  input  wire logic        cam_control_active_in,
  input  wire logic [7:0]  cam_item49_in,
  input  wire logic        override_select_input_in,
  // Response
  output logic             rsp_valid_out,
  output logic             rsp_exception_out,
  output logic      [7:0]  rsp_exc_code_out,
  output logic      [31:0] rsp_data_out,
  // Motion commands
  output logic             simultaneous_start_out,
  output logic             host_force_stop_command_out,
  output logic      [15:0] speed_override_out,
  output logic      [15:0] forward_torque_cap_out,
  output logic      [15:0] reverse_torque_cap_out,
  output logic      [7:0]  cam_select_out,
  output logic      [31:0] cam_cycle_length_out,
  output logic      [31:0] cam_stroke_length_out
);
  smcr_dec_if dec ();

  logic        rsp_valid_reg,  rsp_valid_next;
  logic        rsp_exc_reg,    rsp_exc_next;
  logic [7:0]  rsp_code_reg,   rsp_code_next;
  logic [31:0] rsp_data_reg,   rsp_data_next;
  logic        start_reg,      start_next;
  logic        stop_reg,       stop_next;
  logic [15:0] override_reg,   override_next;
  logic [15:0] ovr_eff_reg;
  logic [15:0] fwd_cap_reg,    fwd_cap_next;
  logic [15:0] rev_cap_reg,    rev_cap_next;
  logic [7:0]  target_cam_reg, target_cam_next;
  logic [7:0]  cam_eff_reg;
  logic [31:0] cycle_reg,      cycle_next;
  logic [31:0] stroke_reg,     stroke_next;

  logic [15:0] ovr_eff;
  logic [7:0]  cam_eff;
  logic        is_rd;
  logic        is_wr;
  logic        flag_reg;
  logic        bcast_ok;
  logic [7:0]  exc;
  logic        wr_go;
  logic [31:0] rd_val;

  smcr_decode u_decode (
    .dec (dec.decoder)
  );

  smcr_motion_sel u_motion_sel (
    .override_reg_in          (override_reg),
    .target_cam_in            (target_cam_reg),
    .override_select_input_in (override_select_input_in),
    .cam_item49_in            (cam_item49_in),
    .override_eff_out         (ovr_eff),
    .cam_eff_out              (cam_eff)
  );

  // Request checking
  always_comb begin
    dec.addr = req_addr_in;
    is_rd    = (req_func_in == smcr_pkg::FC_READ_HOLDING);
    is_wr    = (req_func_in == smcr_pkg::FC_PRESET_MULTIPLE);
    flag_reg = (dec.entry == smcr_pkg::E_SIM_START) ||
               (dec.entry == smcr_pkg::E_FORCE_STOP);
    // Force stop passes even when broadcasts are disabled
    bcast_ok = !req_broadcast_in || broadcast_enable_in ||
               (dec.entry == smcr_pkg::E_FORCE_STOP);
    exc = smcr_pkg::EXC_NONE;
    if (!is_rd && !is_wr) begin
      exc = smcr_pkg::EXC_FUNCTION;
    end else if (dec.entry == smcr_pkg::E_NONE ||
                 (is_rd && !dec.rd_ok) || (is_wr && !dec.wr_ok)) begin
      exc = smcr_pkg::EXC_ADDRESS;
    end else if (req_qty_in != {14'h0000, dec.words}) begin
      exc = smcr_pkg::EXC_VALUE;
    end else if (is_wr && flag_reg && req_wdata_in[31:1] != 31'h0) begin
      exc = smcr_pkg::EXC_VALUE;
    end
    wr_go = req_valid_in && is_wr && exc == smcr_pkg::EXC_NONE &&
            bcast_ok;
  end

  // Read data selection
  always_comb begin
    rd_val = 32'h0000_0000;
    case (dec.entry)
      smcr_pkg::E_TARGET_CAM: rd_val = {24'h000000, target_cam_reg};
      smcr_pkg::E_ACTIVE_CAM: begin
        if (cam_control_active_in) begin
          rd_val = {24'h000000, active_cam_in};
        end
      end
      smcr_pkg::E_CAM_CYCLE:  rd_val = cycle_reg;
      smcr_pkg::E_CAM_STROKE: rd_val = stroke_reg;
      smcr_pkg::E_OVERRIDE:   rd_val = {16'h0000, override_reg};
      smcr_pkg::E_FWD_TORQUE: rd_val = {16'h0000, fwd_cap_reg};
      smcr_pkg::E_REV_TORQUE: rd_val = {16'h0000, rev_cap_reg};
      // Shares its source with the position monitor
      smcr_pkg::E_POSITION:   rd_val = actual_position_in;
      smcr_pkg::E_SPEED:      rd_val = actual_speed_in;
      smcr_pkg::E_TORQUE:     rd_val = {16'h0000, actual_torque_in};
      default:                rd_val = 32'h0000_0000;
    endcase
  end

  // Next register values
  always_comb begin
    start_next      = start_reg;
    stop_next       = stop_reg;
    override_next   = override_reg;
    fwd_cap_next    = fwd_cap_reg;
    rev_cap_next    = rev_cap_reg;
    target_cam_next = target_cam_reg;
    cycle_next      = cycle_reg;
    stroke_next     = stroke_reg;
    if (wr_go) begin
      case (dec.entry)
        smcr_pkg::E_SIM_START:  start_next = req_wdata_in[0];
        smcr_pkg::E_FORCE_STOP: stop_next = req_wdata_in[0];
        // Range is the master's to keep; stored as written
        smcr_pkg::E_OVERRIDE:   override_next = req_wdata_in[15:0];
        smcr_pkg::E_FWD_TORQUE: fwd_cap_next = req_wdata_in[15:0];
        smcr_pkg::E_REV_TORQUE: rev_cap_next = req_wdata_in[15:0];
        smcr_pkg::E_TARGET_CAM: target_cam_next = req_wdata_in[7:0];
        smcr_pkg::E_CAM_CYCLE:  cycle_next = req_wdata_in;
        smcr_pkg::E_CAM_STROKE: stroke_next = req_wdata_in;
        default:                start_next = start_reg;
      endcase
    end
    // Broadcast requests never get an answer
    rsp_valid_next = req_valid_in && !req_broadcast_in;
    rsp_exc_next   = exc != smcr_pkg::EXC_NONE;
    rsp_code_next  = exc;
    rsp_data_next  = 32'h0000_0000;
    if (is_rd && exc == smcr_pkg::EXC_NONE) begin
      rsp_data_next = rd_val;
    end
    if (!rsp_valid_next) begin
      rsp_exc_next  = 1'b0;
      rsp_code_next = smcr_pkg::EXC_NONE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rsp_valid_reg  <= 1'b0;
      rsp_exc_reg    <= 1'b0;
      rsp_code_reg   <= smcr_pkg::EXC_NONE;
      rsp_data_reg   <= 32'h0000_0000;
      start_reg      <= 1'b0;
      stop_reg       <= 1'b0;
      override_reg   <= smcr_pkg::RST_OVERRIDE;
      ovr_eff_reg    <= smcr_pkg::OVERRIDE_NEUTRAL;
      fwd_cap_reg    <= smcr_pkg::RST_TORQUE_CAP;
      rev_cap_reg    <= smcr_pkg::RST_TORQUE_CAP;
      target_cam_reg <= smcr_pkg::RST_TARGET_CAM;
      cam_eff_reg    <= smcr_pkg::RST_TARGET_CAM;
      cycle_reg      <= smcr_pkg::RST_CAM_CYCLE;
      stroke_reg     <= smcr_pkg::RST_CAM_STROKE;
    end else begin
      rsp_valid_reg  <= rsp_valid_next;
      rsp_exc_reg    <= rsp_exc_next;
      rsp_code_reg   <= rsp_code_next;
      rsp_data_reg   <= rsp_data_next;
      start_reg      <= start_next;
      stop_reg       <= stop_next;
      override_reg   <= override_next;
      ovr_eff_reg    <= ovr_eff;
      fwd_cap_reg    <= fwd_cap_next;
      rev_cap_reg    <= rev_cap_next;
      target_cam_reg <= target_cam_next;
      cam_eff_reg    <= cam_eff;
      cycle_reg      <= cycle_next;
      stroke_reg     <= stroke_next;
    end
  end

  assign rsp_valid_out               = rsp_valid_reg;
  assign rsp_exception_out           = rsp_exc_reg;
  assign rsp_exc_code_out            = rsp_code_reg;
  assign rsp_data_out                = rsp_data_reg;
  assign simultaneous_start_out      = start_reg;
  assign host_force_stop_command_out = stop_reg;
  assign speed_override_out          = ovr_eff_reg;
  assign forward_torque_cap_out      = fwd_cap_reg;
  assign reverse_torque_cap_out      = rev_cap_reg;
  assign cam_select_out              = cam_eff_reg;
  assign cam_cycle_length_out        = cycle_reg;
  assign cam_stroke_length_out       = stroke_reg;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  property p_start;
    wr_go && dec.entry == smcr_pkg::E_SIM_START
      |=> simultaneous_start_out == $past(req_wdata_in[0]);
  endproperty
  a_start: assert property (p_start)
    else $error("simultaneous start does not follow write");

  property p_stop_bcast;
    req_valid_in && req_broadcast_in && !broadcast_enable_in &&
    req_func_in == smcr_pkg::FC_PRESET_MULTIPLE &&
    req_addr_in == smcr_pkg::ADDR_FORCE_STOP &&
    req_qty_in == 16'h0001 && req_wdata_in == 32'h0000_0001
      |=> host_force_stop_command_out && !rsp_valid_out;
  endproperty
  a_stop_bcast: assert property (p_stop_bcast)
    else $error("broadcast force stop not taken");

  property p_stop;
    wr_go && dec.entry == smcr_pkg::E_FORCE_STOP
      |=> host_force_stop_command_out == $past(req_wdata_in[0]);
  endproperty
  a_stop: assert property (p_stop)
    else $error("force stop does not follow write");

  property p_override;
    !override_select_input_in
      |=> speed_override_out == smcr_pkg::OVERRIDE_NEUTRAL;
  endproperty
  a_override: assert property (p_override)
    else $error("override applied without selection");

  property p_func;
    req_valid_in && !req_broadcast_in &&
    req_func_in != smcr_pkg::FC_READ_HOLDING &&
    req_func_in != smcr_pkg::FC_PRESET_MULTIPLE
      |=> rsp_valid_out && rsp_exception_out &&
          rsp_exc_code_out == smcr_pkg::EXC_FUNCTION;
  endproperty
  a_func: assert property (p_func)
    else $error("unsupported function not refused");

  property p_fwd_roundtrip;
    wr_go && dec.entry == smcr_pkg::E_FWD_TORQUE
      |=> forward_torque_cap_out == $past(req_wdata_in[15:0]);
  endproperty
  a_fwd_roundtrip: assert property (p_fwd_roundtrip)
    else $error("forward torque cap not stored");

  property p_rev_roundtrip;
    wr_go && dec.entry == smcr_pkg::E_REV_TORQUE
      |=> reverse_torque_cap_out == $past(req_wdata_in[15:0]);
  endproperty
  a_rev_roundtrip: assert property (p_rev_roundtrip)
    else $error("reverse torque cap not stored");

  property p_position;
    req_valid_in && !req_broadcast_in && is_rd &&
    req_addr_in == smcr_pkg::ADDR_POSITION && req_qty_in == 16'h0002
      |=> rsp_valid_out && !rsp_exception_out &&
          rsp_data_out == $past(actual_position_in);
  endproperty
  a_position: assert property (p_position)
    else $error("position read mismatch");

  property p_cam;
    1'b1 |=> cam_select_out == (($past(cam_item49_in) == 8'h00) ?
             $past(target_cam_reg) : $past(cam_item49_in));
  endproperty
  a_cam: assert property (p_cam)
    else $error("wrong cam number selected");

  property p_qty;
    req_valid_in && !req_broadcast_in && is_rd && dec.rd_ok &&
    req_qty_in > 16'h0002
      |=> rsp_exception_out && rsp_exc_code_out == smcr_pkg::EXC_VALUE;
  endproperty
  a_qty: assert property (p_qty)
    else $error("over-long request not refused");

  property p_cycle;
    wr_go && dec.entry == smcr_pkg::E_CAM_CYCLE
      |=> cam_cycle_length_out == $past(req_wdata_in);
  endproperty
  a_cycle: assert property (p_cycle)
    else $error("cam cycle length not stored");
endmodule : smcr_bank

// [logic/smcr_decode.sv]
// Register number decoder: entry, size and access rights
`timescale 1ns/1ps
module smcr_decode (
  smcr_dec_if.decoder dec
);
  always_comb begin
    dec.entry = smcr_pkg::E_NONE;
    dec.words = smcr_pkg::WORDS_ONE;
    dec.rd_ok = 1'b0;
    dec.wr_ok = 1'b0;
    if (dec.addr == smcr_pkg::ADDR_TARGET_CAM) begin
      dec.entry = smcr_pkg::E_TARGET_CAM;
      dec.rd_ok = 1'b1;
      dec.wr_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_ACTIVE_CAM) begin
      dec.entry = smcr_pkg::E_ACTIVE_CAM;
      dec.rd_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_CAM_CYCLE) begin
      dec.entry = smcr_pkg::E_CAM_CYCLE;
      dec.words = smcr_pkg::WORDS_TWO;
      dec.rd_ok = 1'b1;
      dec.wr_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_CAM_STROKE) begin
      dec.entry = smcr_pkg::E_CAM_STROKE;
      dec.words = smcr_pkg::WORDS_TWO;
      dec.rd_ok = 1'b1;
      dec.wr_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_SIM_START) begin
      dec.entry = smcr_pkg::E_SIM_START;
      dec.wr_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_FORCE_STOP) begin
      dec.entry = smcr_pkg::E_FORCE_STOP;
      dec.wr_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_OVERRIDE) begin
      dec.entry = smcr_pkg::E_OVERRIDE;
      dec.rd_ok = 1'b1;
      dec.wr_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_FWD_TORQUE) begin
      dec.entry = smcr_pkg::E_FWD_TORQUE;
      dec.rd_ok = 1'b1;
      dec.wr_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_REV_TORQUE) begin
      dec.entry = smcr_pkg::E_REV_TORQUE;
      dec.rd_ok = 1'b1;
      dec.wr_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_POSITION) begin
      dec.entry = smcr_pkg::E_POSITION;
      dec.words = smcr_pkg::WORDS_TWO;
      dec.rd_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_SPEED) begin
      dec.entry = smcr_pkg::E_SPEED;
      dec.words = smcr_pkg::WORDS_TWO;
      dec.rd_ok = 1'b1;
    end else if (dec.addr == smcr_pkg::ADDR_TORQUE) begin
      dec.entry = smcr_pkg::E_TORQUE;
      dec.rd_ok = 1'b1;
    end
  end
endmodule : smcr_decode

// [logic/smcr_motion_sel.sv]
// Selection of the override and cam number that motion really uses
`timescale 1ns/1ps
module smcr_motion_sel (
  // Stored settings
  input  wire logic [15:0] override_reg_in,
  input  wire logic [7:0]  target_cam_in,
  // Motion side inputs
  input  wire logic        override_select_input_in,
  input  wire logic [7:0]  cam_item49_in,
  // Effective values
  output logic      [15:0] override_eff_out,
  output logic      [7:0]  cam_eff_out
);
  always_comb begin
    override_eff_out = smcr_pkg::OVERRIDE_NEUTRAL;
    if (override_select_input_in) begin
      override_eff_out = override_reg_in;
    end
    // A nonzero item 49 beats the number written over the link
    cam_eff_out = (cam_item49_in == 8'h00) ? target_cam_in
                                           : cam_item49_in;
  end
endmodule : smcr_motion_sel

// [shared/smcr_dec_if.sv]
// Address lookup results passed from the decoder to the register bank
`timescale 1ns/1ps
interface smcr_dec_if;
  logic [15:0]         addr;
  smcr_pkg::smcr_entry_t entry;
  logic [1:0]          words;
  logic                rd_ok;
  logic                wr_ok;

  modport decoder (input addr, output entry, words, rd_ok, wr_ok);
  modport user    (output addr, input entry, words, rd_ok, wr_ok);
endinterface : smcr_dec_if

// [shared/smcr_pkg.sv]
// Constants and types shared by the servo motion command register bank
package smcr_pkg;
  // Modbus function codes
  localparam logic [7:0]  FC_READ_HOLDING    = 8'h03;
  localparam logic [7:0]  FC_PRESET_MULTIPLE = 8'h10;
  // Modbus exception codes
  localparam logic [7:0]  EXC_NONE           = 8'h00;
  localparam logic [7:0]  EXC_FUNCTION       = 8'h01;
  localparam logic [7:0]  EXC_ADDRESS        = 8'h02;
  localparam logic [7:0]  EXC_VALUE          = 8'h03;
  // Register numbers
  localparam logic [15:0] ADDR_TARGET_CAM    = 16'h2D80;
  localparam logic [15:0] ADDR_ACTIVE_CAM    = 16'h2D82;
  localparam logic [15:0] ADDR_CAM_CYCLE     = 16'h2D84;
  localparam logic [15:0] ADDR_CAM_STROKE    = 16'h2D85;
  localparam logic [15:0] ADDR_SIM_START     = 16'h2D9A;
  localparam logic [15:0] ADDR_FORCE_STOP    = 16'h2D9B;
  localparam logic [15:0] ADDR_OVERRIDE      = 16'h2DB0;
  localparam logic [15:0] ADDR_FWD_TORQUE    = 16'h60E0;
  localparam logic [15:0] ADDR_REV_TORQUE    = 16'h60E1;
  localparam logic [15:0] ADDR_POSITION      = 16'h6064;
  localparam logic [15:0] ADDR_SPEED         = 16'h606C;
  localparam logic [15:0] ADDR_TORQUE        = 16'h6077;
  // Register widths in Modbus words
  localparam logic [1:0]  WORDS_ONE          = 2'h1;
  localparam logic [1:0]  WORDS_TWO          = 2'h2;
  // Override applied while the selection input is off (100 percent)
  localparam logic [15:0] OVERRIDE_NEUTRAL   = 16'h0064;
  // Values after reset
  localparam logic [7:0]  RST_TARGET_CAM     = 8'h00;
  localparam logic [31:0] RST_CAM_CYCLE      = 32'h0000_0000;
  localparam logic [31:0] RST_CAM_STROKE     = 32'h0000_0000;
  localparam logic [15:0] RST_OVERRIDE       = 16'h0064;
  localparam logic [15:0] RST_TORQUE_CAP     = 16'h0000;

  typedef enum logic [3:0] {
    E_NONE,
    E_TARGET_CAM,
    E_ACTIVE_CAM,
    E_CAM_CYCLE,
    E_CAM_STROKE,
    E_SIM_START,
    E_FORCE_STOP,
    E_OVERRIDE,
    E_FWD_TORQUE,
    E_REV_TORQUE,
    E_POSITION,
    E_SPEED,
    E_TORQUE
  } smcr_entry_t;
endpackage : smcr_pkg

// [verif/smcr_master_model.sv]
// Modbus master stand-in driving the parsed request port of the bank
`timescale 1ns/1ps
module smcr_master_model (
  // Clock
  input  wire logic        clk_sys_in,
  // Parsed request
  output logic             req_valid_out,
  output logic             req_broadcast_out,
  output logic      [7:0]  req_func_out,
  output logic      [15:0] req_addr_out,
  output logic      [15:0] req_qty_out,
  output logic      [31:0] req_wdata_out
);
  initial begin
    req_valid_out     = 1'b0;
    req_broadcast_out = 1'b1;
    req_func_out      = 8'hA5;
    req_addr_out      = 16'h5A5A;
    req_qty_out       = 16'hA5A5;
    req_wdata_out     = 32'h5A5A_A5A5;
  end

  // One request for one cycle; fields are inverted once released so a
  // stale request can never be mistaken for a held one
  task automatic issue(input logic bc, input logic [7:0] fn,
                       input logic [15:0] ad, input logic [15:0] qt,
                       input logic [31:0] wd);
    @(posedge clk_sys_in);
    #1;
    req_valid_out     = 1'b1;
    req_broadcast_out = bc;
    req_func_out      = fn;
    req_addr_out      = ad;
    req_qty_out       = qt;
    req_wdata_out     = wd;
    @(posedge clk_sys_in);
    #1;
    req_valid_out     = 1'b0;
    req_broadcast_out = ~bc;
    req_func_out      = ~fn;
    req_addr_out      = ~ad;
    req_qty_out       = ~qt;
    req_wdata_out     = ~wd;
  endtask : issue
endmodule : smcr_master_model

// [verif/tb_smcr_bank.sv]
// Self-checking bench for the motion command register bank
`timescale 1ns/1ps
module tb_smcr_bank;
  typedef struct packed {
    logic [7:0]  fn;
    logic [15:0] ad;
    logic [15:0] qt;
    logic [31:0] wd;
    logic [7:0]  exc;
    logic [31:0] rd;
  } smcr_row_t;
  localparam logic [7:0]  WR  = smcr_pkg::FC_PRESET_MULTIPLE;
  localparam logic [7:0]  RD  = smcr_pkg::FC_READ_HOLDING;
  localparam logic [7:0]  OK  = smcr_pkg::EXC_NONE;
  localparam logic [7:0]  X1  = smcr_pkg::EXC_FUNCTION;
  localparam logic [7:0]  X2  = smcr_pkg::EXC_ADDRESS;
  localparam logic [7:0]  X3  = smcr_pkg::EXC_VALUE;
  localparam logic [15:0] Q1  = 16'h0001;
  localparam logic [15:0] Q2  = 16'h0002;
  localparam logic [31:0] Z   = 32'h0000_0000;
  localparam logic [31:0] POS = 32'h89AB_CDEF;
  localparam logic [31:0] SPD = 32'hFFFF_FC18;
  logic        clk_sys_in, resetn_in, req_valid_in, req_broadcast_in;
  logic [7:0]  req_func_in, active_cam_in, cam_item49_in, rsp_exc_code_out;
  logic [15:0] req_addr_in, req_qty_in, actual_torque_in;
  logic [31:0] req_wdata_in, actual_position_in, actual_speed_in;
  logic        broadcast_enable_in, cam_control_active_in;
  logic        override_select_input_in, rsp_valid_out, rsp_exception_out;
  logic        simultaneous_start_out, host_force_stop_command_out;
  logic [31:0] rsp_data_out, cam_cycle_length_out, cam_stroke_length_out;
  logic [15:0] speed_override_out, forward_torque_cap_out;
  logic [15:0] reverse_torque_cap_out;
  logic [7:0]  cam_select_out;
  int          bad_count, compares;
  smcr_row_t   rows [25];

  smcr_bank i_smcr_bank (.clk_sys_in, .resetn_in, .req_valid_in,
    .req_broadcast_in, .req_func_in, .req_addr_in, .req_qty_in,
    .req_wdata_in, .broadcast_enable_in, .actual_position_in,
    .actual_speed_in, .actual_torque_in, .active_cam_in,
    .cam_control_active_in, .cam_item49_in, .override_select_input_in,
    .rsp_valid_out, .rsp_exception_out, .rsp_exc_code_out, .rsp_data_out,
    .simultaneous_start_out, .host_force_stop_command_out,
    .speed_override_out, .forward_torque_cap_out, .reverse_torque_cap_out,
    .cam_select_out, .cam_cycle_length_out, .cam_stroke_length_out);

  smcr_master_model i_smcr_master_model (.clk_sys_in,
    .req_valid_out(req_valid_in), .req_broadcast_out(req_broadcast_in),
    .req_func_out(req_func_in), .req_addr_out(req_addr_in),
    .req_qty_out(req_qty_in), .req_wdata_out(req_wdata_in));

  task automatic check(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : check

  task automatic send(input logic bc, input logic [7:0] fn,
                      input logic [15:0] ad, input logic [15:0] qt,
                      input logic [31:0] wd);
    i_smcr_master_model.issue(bc, fn, ad, qt, wd);
  endtask : send

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cycles

  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    bad_count++;
    $display("BAD watchdog expected end seen hang");
    stop_test();
  end

  initial begin
    rows = '{
      '{WR, 16'h60E0, Q1, 32'h0000_04D2, OK, Z},
      '{RD, 16'h60E0, Q1, Z, OK, 32'h0000_04D2},
      '{WR, 16'h60E1, Q1, 32'h0000_0320, OK, Z},
      '{RD, 16'h60E1, Q1, Z, OK, 32'h0000_0320},
      '{WR, 16'h2DB0, Q1, 32'h0000_00C8, OK, Z},
      '{RD, 16'h2DB0, Q1, Z, OK, 32'h0000_00C8},
      '{WR, 16'h2D80, Q1, 32'h0000_0005, OK, Z},
      '{RD, 16'h2D80, Q1, Z, OK, 32'h0000_0005},
      '{WR, 16'h2D84, Q2, 32'h1234_5678, OK, Z},
      '{RD, 16'h2D84, Q2, Z, OK, 32'h1234_5678},
      '{WR, 16'h2D85, Q2, 32'hA5A5_5A5A, OK, Z},
      '{RD, 16'h2D85, Q2, Z, OK, 32'hA5A5_5A5A},
      '{RD, 16'h6064, Q2, Z, OK, POS},
      '{RD, 16'h606C, Q2, Z, OK, SPD},
      '{RD, 16'h6077, Q1, Z, OK, 32'h0000_03E8},
      '{RD, 16'h2D82, Q1, Z, OK, 32'h0000_0009},
      '{8'h04, 16'h60E0, Q1, Z, X1, Z},
      '{RD, 16'h2D9A, Q1, Z, X2, Z},
      '{WR, 16'h6064, Q2, POS, X2, Z},
      '{RD, 16'h60E0, Q2, Z, X3, Z},
      '{WR, 16'h2D9B, Q1, 32'h0000_0002, X3, Z},
      '{RD, 16'h1234, Q1, Z, X2, Z},
      '{WR, 16'h2D84, Q1, 32'h0000_0001, X3, Z},
      '{RD, 16'h2D84, 16'h0003, Z, X3, Z},
      '{RD, 16'h2D84, Q2, Z, OK, 32'h1234_5678}};
    resetn_in = 1'b0;
    broadcast_enable_in = 1'b0;
    actual_position_in = POS;
    actual_speed_in = SPD;
    actual_torque_in = 16'h03E8;
    active_cam_in = 8'h09;
    cam_control_active_in = 1'b1;
    cam_item49_in = 8'h00;
    override_select_input_in = 1'b0;
    cycles(12);
    resetn_in = 1'b1;
    check("start_rst", Z, {31'h0, simultaneous_start_out});
    check("stop_rst", Z, {31'h0, host_force_stop_command_out});
    check("ovr_rst", 32'h0000_0064, {16'h0, speed_override_out});
    check("fwd_rst", Z, {16'h0, forward_torque_cap_out});
    check("rsp_rst", Z, {31'h0, rsp_valid_out});
    foreach (rows[i]) begin
      send(1'b0, rows[i].fn, rows[i].ad, rows[i].qt, rows[i].wd);
      check("rsp_valid", 32'h1, {31'h0, rsp_valid_out});
      check("rsp_exc", {31'h0, rows[i].exc !== OK},
            {31'h0, rsp_exception_out});
      if (rows[i].exc !== OK)
        check("exc_code", {24'h0, rows[i].exc},
              {24'h0, rsp_exc_code_out});
      else
        check("rsp_data", rows[i].rd, rsp_data_out);
    end
    check("fwd_cap", 32'h0000_04D2, {16'h0, forward_torque_cap_out});
    check("rev_cap", 32'h0000_0320, {16'h0, reverse_torque_cap_out});
    check("cycle", 32'h1234_5678, cam_cycle_length_out);
    check("stroke", 32'hA5A5_5A5A, cam_stroke_length_out);
    check("cam_tgt", 32'h0000_0005, {24'h0, cam_select_out});
    check("ovr_off", 32'h0000_0064, {16'h0, speed_override_out});
    override_select_input_in = 1'b1;
    cam_item49_in = 8'h07;
    cam_control_active_in = 1'b0;
    cycles(2);
    check("ovr_on", 32'h0000_00C8, {16'h0, speed_override_out});
    check("cam_49", 32'h0000_0007, {24'h0, cam_select_out});
    send(1'b0, RD, 16'h2D82, Q1, Z);
    check("cam_idle", Z, rsp_data_out);
    // Table number was chosen before the trigger
    send(1'b0, WR, 16'h2D9A, Q1, 32'h0000_0001);
    check("start_on", 32'h1, {31'h0, simultaneous_start_out});
    send(1'b0, WR, 16'h2D9A, Q1, Z);
    check("start_off", Z, {31'h0, simultaneous_start_out});
    // Broadcast stop must land even with broadcast writes disabled
    send(1'b1, WR, 16'h2D9B, Q1, 32'h0000_0001);
    check("bc_rsp", Z, {31'h0, rsp_valid_out});
    check("stop_bc", 32'h1, {31'h0, host_force_stop_command_out});
    send(1'b1, WR, 16'h60E0, Q1, 32'h0000_0001);
    check("bc_off", 32'h0000_04D2, {16'h0, forward_torque_cap_out});
    broadcast_enable_in = 1'b1;
    send(1'b1, WR, 16'h60E0, Q1, 32'h0000_0002);
    check("bc_on", 32'h0000_0002, {16'h0, forward_torque_cap_out});
    send(1'b0, WR, 16'h2D9B, Q1, Z);
    check("stop_off", Z, {31'h0, host_force_stop_command_out});
    send(1'b0, 8'h06, 16'h60E1, Q1, 32'h0000_0007);
    check("fn06", {24'h0, X1}, {24'h0, rsp_exc_code_out});
    check("fn06_cap", 32'h0000_0320, {16'h0, reverse_torque_cap_out});
    // Second reset in mid-run clears the volatile settings
    resetn_in = 1'b0;
    cycles(2);
    resetn_in = 1'b1;
    check("fwd_rst2", Z, {16'h0, forward_torque_cap_out});
    check("cyc_rst2", Z, cam_cycle_length_out);
    check("strk_rst2", Z, cam_stroke_length_out);
    send(1'b0, RD, 16'h2DB0, Q1, Z);
    check("ovr_rd2", 32'h0000_0064, rsp_data_out);
    stop_test();
  end
endmodule : tb_smcr_bank
